// ---- rtl/dac_cfg.svh ----
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH

// Timing.
`define CLK_PERIOD_NS 10
`define SCL_PERIOD_NS 10000
`define QTR_CYC ((`SCL_PERIOD_NS) / (4 * `CLK_PERIOD_NS))

// Device sub-addresses and fields.
`define NUM_CH       5
`define SUB_CTRL     3'h0
`define REF_BIT      4
`define PUP_BIT      7
`define REG_RESET    8'h00

// Controller register offsets.
`define C_TXD  3'h0
`define C_CMD  3'h1
`define C_STAT 3'h2
`define C_RXD  3'h3
`define C_IRQ  3'h4
`define C_MASK 3'h5
`define C_DIV  3'h6

// Controller command and event bits.
`define CMD_START 0
`define CMD_WRITE 1
`define CMD_READ  2
`define CMD_STOP  3
`define CMD_NACK  4
`define IRQ_DONE  0
`define IRQ_NACK  1

`endif

// ---- rtl/dac_pkg.sv ----
// Purpose: State types for both ends of the link, one enum per end.
// Assumes: Nothing.
// Notes:   Constants live in dac_cfg.svh.
package dac_pkg;

  typedef enum logic [2:0]
  {
    D_IDLE  = 3'b000,
    D_ADDR  = 3'b001,
    D_RX    = 3'b010,
    D_ACK   = 3'b011,
    D_TX    = 3'b100,
    D_TXACK = 3'b101
  } dev_state_t;

  typedef enum logic [1:0]
  {
    C_IDLE  = 2'b00,
    C_START = 2'b01,
    C_BIT   = 2'b10,
    C_STOP  = 2'b11
  } ctl_state_t;

endpackage : dac_pkg

// ---- rtl/i2c_link_if.sv ----
// Purpose: Two-wire link between the controller and the converter slave.
// Assumes: Open-drain wires with pull-ups.
// Notes:   Wire levels are resolved here from each party's enable.
`timescale 1ns/1ps
`default_nettype none

interface i2c_link_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // A driver pulls low only when enabled with a low value; else pull-up.
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));

  modport device
  (
    input  scl,
    input  sda,
    output sda_d_o,
    output sda_d_oe
  );

  modport ctrl
  (
    input  sda,
    output scl_m_o,
    output scl_m_oe,
    output sda_m_o,
    output sda_m_oe
  );
endinterface : i2c_link_if

`default_nettype wire

// ---- rtl/pin_sync.sv ----
// Purpose: Two-flop synchroniser for inputs from outside the clock domain.
// Assumes: Inputs are levels.
// Notes:   Only the second stage may be read.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(parameter int W = 1)
(
  input  wire logic         i_mclk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      meta_r <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : pin_sync

`default_nettype wire

// ---- rtl/dac_reg_slave.sv ----
// Purpose: Register slave of a five-channel converter on a two-wire bus.
// Assumes: Bus clock far slower than i_mclk; all pins asynchronous.
// Notes:   Sub-address 0 is the control byte, 1..5 the channel codes.
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg.svh"

module dac_reg_slave #(
  // Fixed upper address bits; the value is arbitrary.
  parameter logic [3:0] ADDR_HI = 4'h5
)
(
  input  wire logic                    i_mclk,
  input  wire logic                    i_reset_n,
  i2c_link_if.device                   link,
  input  wire logic                    i_address_select_pin0,
  input  wire logic                    i_address_select_pin1,
  input  wire logic                    i_address_select_pin2,
  input  wire logic [3:0]              i_port_pin_levels,
  input  wire logic                    i_supply_dip,
  output logic                         o_ref_sel,
  output logic [3:0]                   o_port_output_switches,
  output logic [`NUM_CH-1:0][7:0]      o_converter_code_regs,
  output logic                         o_power_up_flag
);
  // ---------------------------------------------------------------
  // Input synchronisation and bus events
  // ---------------------------------------------------------------
  logic [9:0]         sync_s;
  logic               scl_s;
  logic               sda_s;
  logic               dip_s;
  logic [2:0]         sel_s;
  logic [3:0]         lv_s;
  logic               scl_d_r;
  logic               sda_d_r;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_ev;
  logic               stop_ev;

  pin_sync #(.W(10)) u_sync
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_async   ({link.scl, link.sda, i_supply_dip, i_address_select_pin2,
                 i_address_select_pin1, i_address_select_pin0,
                 i_port_pin_levels}),
    .o_sync    (sync_s)
  );

  assign scl_s = sync_s[9];
  assign sda_s = sync_s[8];
  assign dip_s = sync_s[7];
  assign sel_s = sync_s[6:4];
  assign lv_s  = sync_s[3:0];

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      scl_d_r <= 1'b0;
      sda_d_r <= 1'b0;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_ev  = scl_s && scl_d_r && !sda_d_r && sda_s;

  // ---------------------------------------------------------------
  // Byte engine
  // ---------------------------------------------------------------
  dac_pkg::dev_state_t state_r;
  logic [3:0]         bit_cnt_r;
  logic [7:0]         shift_r;
  logic [7:0]         tx_r;
  logic               rw_r;
  logic               mack_r;
  logic               sda_oe_r;
  logic               sub_ok_r;
  logic [2:0]         ptr_r;
  logic               addr_ok;
  logic               byte_end;
  logic               wr_ev;
  logic               sub_ev;
  logic               load_ev;
  logic               read_seen_r;
  logic               por_done_r;
  logic               power_up_flag_r;
  logic [7:0]         status;

  assign addr_ok  = shift_r[7:1] == {ADDR_HI, sel_s};
  assign byte_end = scl_fall && state_r == dac_pkg::D_RX && bit_cnt_r == 4'h8;
  assign sub_ev   = byte_end && !sub_ok_r;
  assign wr_ev    = byte_end && sub_ok_r;
  assign load_ev  = scl_fall && ((state_r == dac_pkg::D_ACK && rw_r) ||
                                 (state_r == dac_pkg::D_TXACK && mack_r));
  assign status   = {power_up_flag_r, 3'h0, lv_s};

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      state_r   <= dac_pkg::D_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      rw_r      <= 1'b0;
      mack_r    <= 1'b0;
      sda_oe_r  <= 1'b0;
    end
    else if (start_ev)
    begin
      state_r   <= dac_pkg::D_ADDR;
      bit_cnt_r <= 4'h0;
      mack_r    <= 1'b0;
      sda_oe_r  <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_r  <= dac_pkg::D_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (state_r == dac_pkg::D_TXACK)
      begin
        mack_r <= !sda_s;
      end
      else if (state_r == dac_pkg::D_ADDR || state_r == dac_pkg::D_RX)
      begin
        shift_r   <= {shift_r[6:0], sda_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      unique case (state_r)
        dac_pkg::D_IDLE:
        begin
        end
        dac_pkg::D_ADDR,
        dac_pkg::D_RX:
        begin
          if (bit_cnt_r == 4'h8)
          begin
            if (state_r == dac_pkg::D_ADDR && !addr_ok)
            begin
              state_r <= dac_pkg::D_IDLE;
            end
            else
            begin
              sda_oe_r <= 1'b1;
              state_r  <= dac_pkg::D_ACK;
              if (state_r == dac_pkg::D_ADDR)
              begin
                rw_r <= shift_r[0];
              end
            end
          end
        end
        dac_pkg::D_ACK:
        begin
          bit_cnt_r <= 4'h0;
          if (rw_r)
          begin
            tx_r     <= {status[6:0], 1'b0};
            sda_oe_r <= !status[7];
            state_r  <= dac_pkg::D_TX;
          end
          else
          begin
            sda_oe_r <= 1'b0;
            state_r  <= dac_pkg::D_RX;
          end
        end
        dac_pkg::D_TX:
        begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == 4'h7)
          begin
            sda_oe_r <= 1'b0;
            state_r  <= dac_pkg::D_TXACK;
          end
          else
          begin
            sda_oe_r <= !tx_r[7];
            tx_r     <= {tx_r[6:0], 1'b0};
          end
        end
        dac_pkg::D_TXACK:
        begin
          bit_cnt_r <= 4'h0;
          if (mack_r)
          begin
            tx_r     <= {status[6:0], 1'b0};
            sda_oe_r <= !status[7];
            state_r  <= dac_pkg::D_TX;
          end
          else
          begin
            sda_oe_r <= 1'b0;
            state_r  <= dac_pkg::D_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sda_d_o  = 1'b0;
  assign link.sda_d_oe = sda_oe_r;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [4:0] ctrl_r;
  logic [7:0] code_r [`NUM_CH];

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n || start_ev)
    begin
      sub_ok_r <= 1'b0;
    end
    else if (sub_ev)
    begin
      sub_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      ptr_r <= `SUB_CTRL;
    end
    else if (sub_ev)
    begin
      ptr_r <= shift_r[2:0];
    end
    else if (wr_ev)
    begin
      ptr_r <= ptr_r + 3'h1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      ctrl_r <= 5'h00;
      for (int i = 0; i < `NUM_CH; i++)
      begin
        code_r[i] <= `REG_RESET;
      end
    end
    else if (wr_ev)
    begin
      if (ptr_r == `SUB_CTRL)
      begin
        ctrl_r <= shift_r[4:0];
      end
      else if (ptr_r <= 3'(`NUM_CH))
      begin
        code_r[ptr_r - 3'h1] <= shift_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Power-up flag
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      por_done_r  <= 1'b0;
      read_seen_r <= 1'b0;
    end
    else
    begin
      por_done_r <= 1'b1;
      if (start_ev || stop_ev)
      begin
        read_seen_r <= 1'b0;
      end
      else if (load_ev)
      begin
        read_seen_r <= 1'b1;
      end
    end
  end

  // Setting the flag wins over a clear in the same cycle.
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      power_up_flag_r <= 1'b0;
    end
    else if (!por_done_r || dip_s)
    begin
      power_up_flag_r <= 1'b1;
    end
    else if (stop_ev && read_seen_r)
    begin
      power_up_flag_r <= 1'b0;
    end
  end

  assign o_ref_sel              = ctrl_r[`REF_BIT];
  assign o_port_output_switches = ctrl_r[3:0];
  assign o_power_up_flag        = power_up_flag_r;

  always_comb
  begin
    for (int i = 0; i < `NUM_CH; i++)
    begin
      o_converter_code_regs[i] = code_r[i];
    end
  end
endmodule : dac_reg_slave

`default_nettype wire

// ---- rtl/i2c_master_ctrl.sv ----
// Purpose: Two-wire bus controller with a byte-level command port.
// Assumes: Single master; no clock stretching by the slave.
// Notes:   Each bit takes four quarter ticks from the divider.
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg.svh"

module i2c_master_ctrl
(
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  i2c_link_if.ctrl        link,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_irq
);
  // ---------------------------------------------------------------
  // Quarter-bit divider
  // ---------------------------------------------------------------
  dac_pkg::ctl_state_t state_r;
  logic [7:0] div_r;
  logic [7:0] cnt_r;
  logic       qtick;
  logic       sda_s;

  pin_sync #(.W(1)) u_sync
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_async   (link.sda),
    .o_sync    (sda_s)
  );

  assign qtick = cnt_r == div_r;

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n || state_r == dac_pkg::C_IDLE || qtick)
    begin
      cnt_r <= 8'h00;
    end
    else
    begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Bit sequencer
  // ---------------------------------------------------------------
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [4:0] cmd_r;
  logic [7:0] sh_r;
  logic [7:0] txd_r;
  logic [7:0] rxd_r;
  logic       rxack_r;
  logic       scl_oe_r;
  logic       sda_oe_r;
  logic       ev_done_r;
  logic       ev_nack_r;
  logic       launch;
  logic       has_byte;

  assign launch   = i_wr && i_addr == `C_CMD && state_r == dac_pkg::C_IDLE;
  assign has_byte = cmd_r[`CMD_WRITE] || cmd_r[`CMD_READ];

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      state_r   <= dac_pkg::C_IDLE;
      q_r       <= 2'h0;
      bit_r     <= 4'h0;
      cmd_r     <= 5'h00;
      sh_r      <= 8'h00;
      rxd_r     <= 8'h00;
      rxack_r   <= 1'b0;
      scl_oe_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
      ev_done_r <= 1'b0;
      ev_nack_r <= 1'b0;
    end
    else
    begin
      ev_done_r <= 1'b0;
      ev_nack_r <= 1'b0;
      if (launch)
      begin
        cmd_r <= i_wdata[4:0];
        sh_r  <= i_wdata[`CMD_READ] ? 8'hFF : txd_r;
        q_r   <= 2'h0;
        bit_r <= 4'h0;
        if (i_wdata[`CMD_START])
          state_r <= dac_pkg::C_START;
        else if (i_wdata[`CMD_WRITE] || i_wdata[`CMD_READ])
          state_r <= dac_pkg::C_BIT;
        else if (i_wdata[`CMD_STOP])
          state_r <= dac_pkg::C_STOP;
        else
          ev_done_r <= 1'b1;
      end
      else if (qtick)
      begin
        q_r <= q_r + 2'h1;
        unique case (state_r)
          dac_pkg::C_IDLE:
          begin
          end
          dac_pkg::C_START:
          begin
            unique case (q_r)
              2'h0: sda_oe_r <= 1'b0;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b1;
              2'h3:
              begin
                scl_oe_r <= 1'b1;
                bit_r    <= 4'h0;
                if (has_byte)
                  state_r <= dac_pkg::C_BIT;
                else if (cmd_r[`CMD_STOP])
                  state_r <= dac_pkg::C_STOP;
                else
                begin
                  state_r   <= dac_pkg::C_IDLE;
                  ev_done_r <= 1'b1;
                end
              end
            endcase
          end
          dac_pkg::C_BIT:
          begin
            unique case (q_r)
              2'h0:
              begin
                if (bit_r == 4'h8)
                  sda_oe_r <= cmd_r[`CMD_READ] && !cmd_r[`CMD_NACK];
                else
                  sda_oe_r <= !cmd_r[`CMD_READ] && !sh_r[7];
              end
              2'h1: scl_oe_r <= 1'b0;
              2'h2:
              begin
                // Sampled while the clock is high, after its rise.
                if (bit_r == 4'h8)
                  rxack_r <= sda_s;
                else
                  sh_r <= {sh_r[6:0], sda_s};
              end
              2'h3:
              begin
                scl_oe_r <= 1'b1;
                bit_r    <= bit_r + 4'h1;
                if (bit_r == 4'h8)
                begin
                  rxd_r     <= sh_r;
                  ev_nack_r <= cmd_r[`CMD_WRITE] && rxack_r;
                  if (cmd_r[`CMD_STOP])
                    state_r <= dac_pkg::C_STOP;
                  else
                  begin
                    state_r   <= dac_pkg::C_IDLE;
                    ev_done_r <= 1'b1;
                  end
                end
              end
            endcase
          end
          dac_pkg::C_STOP:
          begin
            unique case (q_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b0;
              2'h3:
              begin
                state_r   <= dac_pkg::C_IDLE;
                ev_done_r <= 1'b1;
              end
            endcase
          end
        endcase
      end
    end
  end

  assign link.scl_m_o  = 1'b0;
  assign link.scl_m_oe = scl_oe_r;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = sda_oe_r;

  // ---------------------------------------------------------------
  // Registers and interrupt
  // ---------------------------------------------------------------
  logic [1:0] irq_st_r;
  logic [1:0] mask_r;
  logic [1:0] irq_nxt;

  // A new event wins over the clear by read in the same cycle.
  assign irq_nxt = ((i_rd && i_addr == `C_IRQ) ? 2'h0 : irq_st_r) |
                   {ev_nack_r, ev_done_r};

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      txd_r    <= 8'h00;
      mask_r   <= 2'h0;
      div_r    <= 8'(`QTR_CYC - 1);
      irq_st_r <= 2'h0;
      o_irq    <= 1'b0;
    end
    else
    begin
      irq_st_r <= irq_nxt;
      o_irq    <= |(irq_nxt & mask_r);
      if (i_wr && i_addr == `C_TXD)
        txd_r <= i_wdata;
      if (i_wr && i_addr == `C_MASK)
        mask_r <= i_wdata[1:0];
      if (i_wr && i_addr == `C_DIV)
        div_r <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n || !i_rd)
      o_rdata <= 8'h00;
    else
    begin
      case (i_addr)
        `C_TXD:  o_rdata <= txd_r;
        `C_CMD:  o_rdata <= {3'h0, cmd_r};
        `C_STAT: o_rdata <= {6'h00, rxack_r, state_r != dac_pkg::C_IDLE};
        `C_RXD:  o_rdata <= rxd_r;
        `C_IRQ:  o_rdata <= {6'h00, irq_st_r};
        `C_MASK: o_rdata <= {6'h00, mask_r};
        `C_DIV:  o_rdata <= div_r;
        default: o_rdata <= 8'h00;
      endcase
    end
  end
endmodule : i2c_master_ctrl

`default_nettype wire

// ---- test/dac_link_sva.sv ----
// Purpose: Watches the two-wire link between the controller and the slave.
// Assumes: One clock domain with a synchronous, active-low reset.
// Notes:   Instantiated beside the link in tb_top.
`timescale 1ns/1ps
`default_nettype none

module dac_link_sva
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  logic sda_q_r;
  logic in_frame_r;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      sda_q_r <= 1'b1;
    else
      sda_q_r <= sda;
  end

  // A frame opens when data falls under a high clock and closes when it rises.
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      in_frame_r <= 1'b0;
    else if (scl && sda_q_r && !sda)
      in_frame_r <= 1'b1;
    else if (scl && !sda_q_r && sda)
      in_frame_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_dev_open_drain: assert property (!sda_d_o)
    else $error("device drives a high level");
  chk_ctl_open_drain: assert property (!scl_m_o && !sda_m_o)
    else $error("controller drives a high level");
  chk_dev_edge_low: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device changed data while clock high");
  chk_dev_in_frame: assert property (sda_d_oe |-> in_frame_r)
    else $error("device drives data outside a frame");
  chk_start_clk_low: assert property ($fell(sda) && scl |-> ##[1:20] !scl)
    else $error("clock not lowered after start");
  chk_stop_idle: assert property ($rose(sda) && scl |=> (sda && scl) [*4])
    else $error("bus not idle after stop");
  chk_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  chk_dev_release: assert property ($rose(sda_d_oe) |-> ##[1:250] !sda_d_oe)
    else $error("device holds data line too long");
endmodule : dac_link_sva

`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Bench for the controller and converter slave joined by the link.
// Assumes: The divider is set to 4, so a quarter bit lasts five clocks.
// Notes:   Reset and register checks first, then table cases, then the hand-written ones.
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg.svh"

module tb_top;
  typedef struct packed
  {
    logic [2:0] sub;
    logic [7:0] dat;
  } row_t;

  logic            i_mclk = 1'b0;
  logic            rst_n = 1'b0;
  logic [2:0]      addr = 3'h0;
  logic [7:0]      wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic [7:0]      rdata;
  logic            irq;
  logic [2:0]      sel = 3'h5;
  logic [3:0]      pins = 4'hA;
  logic            dip = 1'b0;
  logic            ref_sel;
  logic [3:0]      sw;
  logic [4:0][7:0] codes;
  logic            pflag;
  logic [7:0]      ectl;
  logic [4:0][7:0] ecode;
  logic [7:0]      v;
  int              err_total = 0;
  int              total_checks = 0;
  // Sub-address and data of single-byte writes; upper control bits are ignored.
  row_t            rows [8] = '{'{3'h0, 8'h1F}, '{3'h1, 8'h00}, '{3'h2, 8'hFF},
    '{3'h3, 8'h80}, '{3'h4, 8'h7F}, '{3'h5, 8'hFC}, '{3'h0, 8'hE5}, '{3'h0, 8'h10}};

  i2c_link_if i2c_link_if_inst ();

  dac_reg_slave #(.ADDR_HI(4'h5)) dac_reg_slave_inst
  (
    .i_mclk(i_mclk), .i_reset_n(rst_n), .link(i2c_link_if_inst),
    .i_address_select_pin0(sel[0]), .i_address_select_pin1(sel[1]),
    .i_address_select_pin2(sel[2]), .i_port_pin_levels(pins), .i_supply_dip(dip),
    .o_ref_sel(ref_sel), .o_port_output_switches(sw), .o_converter_code_regs(codes),
    .o_power_up_flag(pflag)
  );

  i2c_master_ctrl i2c_master_ctrl_inst
  (
    .i_mclk(i_mclk), .i_reset_n(rst_n), .link(i2c_link_if_inst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq)
  );

  dac_link_sva dac_link_sva_inst
  (
    .i_mclk(i_mclk), .i_reset_n(rst_n),
    .scl_m_o(i2c_link_if_inst.scl_m_o), .scl_m_oe(i2c_link_if_inst.scl_m_oe),
    .sda_m_o(i2c_link_if_inst.sda_m_o), .sda_m_oe(i2c_link_if_inst.sda_m_oe),
    .sda_d_o(i2c_link_if_inst.sda_d_o), .sda_d_oe(i2c_link_if_inst.sda_d_oe),
    .scl(i2c_link_if_inst.scl), .sda(i2c_link_if_inst.sda)
  );

  always #5 i_mclk = ~i_mclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // Runs one controller command, waits for its interrupt and reads the events.
  task automatic bus_cmd(input logic [7:0] c, input logic [7:0] tx, input logic [7:0] ex);
    int n;
    n = 0;
    reg_wr(`C_TXD, tx);
    reg_wr(`C_CMD, c);
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge i_mclk);
      n++;
    end
    reg_rd(`C_IRQ, v);
    chk8(v, ex);
  endtask : bus_cmd

  task automatic dev_write(input logic [7:0] ad, input logic [2:0] sub, input logic [7:0] d[$]);
    bus_cmd(8'h03, ad, 8'h01);
    bus_cmd(8'h02, {5'h00, sub}, 8'h01);
    foreach (d[i]) bus_cmd((i == d.size() - 1) ? 8'h0A : 8'h02, d[i], 8'h01);
  endtask : dev_write

  task automatic dev_read(input logic [7:0] ex);
    bus_cmd(8'h03, 8'h5B, 8'h01);
    bus_cmd(8'h1C, 8'h00, 8'h01);
    reg_rd(`C_RXD, v);
    chk8(v, ex);
  endtask : dev_read

  task automatic chk_outs();
    chk8({3'h0, ref_sel, sw}, ectl & 8'h1F);
    for (int i = 0; i < 5; i++) chk8(codes[i], ecode[i]);
  endtask : chk_outs

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    ectl = 8'h00;
    ecode = '0;
    repeat (8) @(posedge i_mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk_outs();
    chk8({7'h00, pflag}, 8'h01);
    reg_wr(`C_DIV, 8'h04);
    reg_wr(`C_MASK, 8'h03);
    reg_rd(`C_MASK, v);
    chk8(v, 8'h03);
    reg_rd(3'h7, v);
    chk8(v, 8'h00);
    foreach (rows[i])
    begin
      dev_write(8'h5A, rows[i].sub, '{rows[i].dat});
      if (rows[i].sub == 3'h0)
        ectl = rows[i].dat;
      else
        ecode[rows[i].sub - 1] = rows[i].dat;
      chk_outs();
    end
    dev_read(8'h8A);
    dev_read(8'h0A);
    chk8({7'h00, pflag}, 8'h00);
    dev_write(8'h5A, 3'h0, '{8'h0B, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
    ectl = 8'h0B;
    ecode = {8'h55, 8'h44, 8'h33, 8'h22, 8'h11};
    chk_outs();
    @(posedge i_mclk);
    dip <= 1'b1;
    pins <= 4'h5;
    repeat (4) @(posedge i_mclk);
    dip <= 1'b0;
    repeat (4) @(posedge i_mclk);
    chk8({7'h00, pflag}, 8'h01);
    dev_read(8'h85);
    // Masked interrupt: the line stays low but the event is still recorded.
    reg_wr(`C_MASK, 8'h00);
    reg_wr(`C_TXD, 8'h5A);
    reg_wr(`C_CMD, 8'h03);
    repeat (400) @(posedge i_mclk);
    chk8({7'h00, irq}, 8'h00);
    reg_rd(`C_IRQ, v);
    chk8(v, 8'h01);
    reg_rd(`C_IRQ, v);
    chk8(v, 8'h00);
    reg_wr(`C_MASK, 8'h03);
    bus_cmd(8'h0A, 8'h01, 8'h01);
    chk_outs();
    @(posedge i_mclk);
    sel <= 3'h4;
    repeat (4) @(posedge i_mclk);
    bus_cmd(8'h03, 8'h5A, 8'h03);
    bus_cmd(8'h08, 8'h00, 8'h01);
    chk_outs();
    dev_write(8'h58, 3'h5, '{8'h3C});
    ecode[4] = 8'h3C;
    chk_outs();
    rst_n <= 1'b0;
    repeat (8) @(posedge i_mclk);
    ectl = 8'h00;
    ecode = '0;
    chk_outs();
    report_and_stop();
  end

  initial
  begin
    #400_000;
    err_total++;
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
